/* File: hdl/fp_order_cmp.v */
// ieee-style ordering compare of two operands of one precision
// purely combinational; caller registers whatever it needs
`timescale 1ns/1ns
`default_nettype none

module fp_order_cmp #(
    parameter EXP_W = 11,
    parameter FRAC_W = 52
) (
    input wire [EXP_W+FRAC_W:0] a, // first operand
    input wire [EXP_W+FRAC_W:0] b, // second operand
    output wire nan_any,           // either operand is a nan
    output wire inf_any,           // either operand is an infinity
    output wire equal,             // ordered and a == b
    output wire greater            // ordered and a > b
);
    localparam W = 1 + EXP_W + FRAC_W;

    wire sign_a = a[W-1];
    wire sign_b = b[W-1];
    wire [W-2:0] mag_a = a[W-2:0];
    wire [W-2:0] mag_b = b[W-2:0];
    wire exp_ones_a = &a[W-2:FRAC_W];
    wire exp_ones_b = &b[W-2:FRAC_W];
    wire frac_nz_a = |a[FRAC_W-1:0];
    wire frac_nz_b = |b[FRAC_W-1:0];
    wire nan_a = exp_ones_a & frac_nz_a;
    wire nan_b = exp_ones_b & frac_nz_b;
    // +0 and -0 are one value
    wire both_zero = ~|mag_a & ~|mag_b;
    wire mag_gt = mag_a > mag_b;
    wire mag_lt = mag_a < mag_b;

    assign nan_any = nan_a | nan_b;
    assign inf_any = (exp_ones_a & ~frac_nz_a) | (exp_ones_b & ~frac_nz_b);
    assign equal = ~nan_any & (both_zero | (a == b));
    assign greater = ~nan_any & ~both_zero &
                     ((~sign_a & sign_b) |
                      (~sign_a & ~sign_b & mag_gt) |
                      (sign_a & sign_b & mag_lt));
endmodule // fp_order_cmp

`default_nettype wire

/* File: hdl/unord_cmp_regs.vh */
// constants for the unordered-or-relation floating-point compare unit
// assumes a 32-bit instruction word and a register file with one-cycle read latency
`ifndef UNORD_CMP_REGS_VH
`define UNORD_CMP_REGS_VH

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define MAJOR_MSB 31
`define MAJOR_LSB 26
`define SRC_A_MSB 20
`define SRC_A_LSB 16
`define SRC_B_MSB 15
`define SRC_B_LSB 11
`define MINOR_MSB 7
`define MINOR_LSB 0

// ----------------------------------------------------------------
// opcode values
// ----------------------------------------------------------------
`define MAJOR_FP_GROUP 6'h32
`define CMP_UNORD_EQ_DOUBLE 8'h38
`define CMP_UNORD_GE_DOUBLE 8'h3b
`define CMP_UNORD_GT_DOUBLE 8'h3a
`define CMP_UNORD_LE_DOUBLE 8'h3d
`define CMP_UNORD_EQ_SINGLE 8'h28
`define CMP_UNORD_GE_SINGLE 8'h2b
`define CMP_UNORD_GT_SINGLE 8'h2a
`define CMP_UNORD_LE_SINGLE 8'h2d

// ----------------------------------------------------------------
// relation codes, flag reset value and pair register step
// ----------------------------------------------------------------
`define REL_EQ 2'h0
`define REL_GE 2'h1
`define REL_GT 2'h2
`define REL_LE 2'h3
`define FLAG_RESET 1'h0
`define PAIR_STEP 5'h01

`endif

/* File: hdl/unordered_fp_compare.v */
// unordered-or-relation set-flag compare unit, single and double forms
// assumes register file answers a read one cycle after gpr_rd_en,
// and the pipeline waits on issue_ready before sending the next word
`timescale 1ns/1ns
`default_nettype none
`include "unord_cmp_regs.vh"

module unordered_fp_compare #(
    parameter XLEN = 32
) (
    input wire core_clk,               // core clock
    input wire nrst,                   // async reset, active low
    input wire issue_valid,            // instruction word offered
    input wire [31:0] issue_instr,     // instruction word
    output wire issue_ready,           // unit idle, can take a word
    output wire issue_claimed,         // word belongs to this group
    output reg gpr_rd_en,              // register file read strobe
    output reg [4:0] gpr_addr_a,       // first source index
    output reg [4:0] gpr_addr_b,       // second source index
    input wire [XLEN-1:0] gpr_data_a,  // first source data
    input wire [XLEN-1:0] gpr_data_b,  // second source data
    output reg flag_we,                // write compare flag in supervision_word
    output reg flag_value,             // compare flag value
    output reg infinity_seen_set       // set infinity_seen_bit in fp_control_status
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_RD_HI = 3'h1;
    localparam S_RD_LO = 3'h2;
    localparam S_WAIT = 3'h3;
    localparam S_EXEC = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] rel;
    reg is_double;
    reg [4:0] src_a;
    reg [4:0] src_b;
    reg [63:0] op_a;
    reg [63:0] op_b;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire [5:0] major = issue_instr[`MAJOR_MSB:`MAJOR_LSB];
    wire [7:0] minor = issue_instr[`MINOR_MSB:`MINOR_LSB];
    reg minor_hit;
    reg [1:0] minor_rel;
    reg minor_double;

    always @* begin
        minor_hit = 1'b1;
        minor_rel = `REL_EQ;
        minor_double = 1'b0;
        case (minor)
            `CMP_UNORD_EQ_DOUBLE: begin
                minor_double = 1'b1;
            end
            `CMP_UNORD_GE_DOUBLE: begin
                minor_rel = `REL_GE;
                minor_double = 1'b1;
            end
            `CMP_UNORD_GT_DOUBLE: begin
                minor_rel = `REL_GT;
                minor_double = 1'b1;
            end
            `CMP_UNORD_LE_DOUBLE: begin
                minor_rel = `REL_LE;
                minor_double = 1'b1;
            end
            `CMP_UNORD_EQ_SINGLE: begin
                minor_rel = `REL_EQ;
            end
            // this code is taken as the ge form; the unordered-only compare lives elsewhere
            `CMP_UNORD_GE_SINGLE: begin
                minor_rel = `REL_GE;
            end
            `CMP_UNORD_GT_SINGLE: begin
                minor_rel = `REL_GT;
            end
            `CMP_UNORD_LE_SINGLE: begin
                minor_rel = `REL_LE;
            end
            default: begin
                minor_hit = 1'b0;
            end
        endcase
    end

    // reserved fields are not checked; other units share the major code
    assign issue_claimed = (major == `MAJOR_FP_GROUP) & minor_hit;
    assign issue_ready = (state == S_IDLE);

    wire take = issue_valid & issue_claimed & issue_ready;
    // only a double on a narrow machine needs a second read
    wire pair_mode = is_double & (XLEN == 32);

    // ----------------------------------------------------------------
    // read data widened to one double word
    // ----------------------------------------------------------------
    wire [63:0] data_a_ext;
    wire [63:0] data_b_ext;

    generate
        if (XLEN == 64) begin : g_wide
            assign data_a_ext = gpr_data_a;
            assign data_b_ext = gpr_data_b;
        end else begin : g_narrow
            assign data_a_ext = {32'h0, gpr_data_a[31:0]};
            assign data_b_ext = {32'h0, gpr_data_b[31:0]};
        end
    endgenerate

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (take) begin
                    next_state = S_RD_HI;
                end
            end
            S_RD_HI: begin
                if (pair_mode) begin
                    next_state = S_RD_LO;
                end else begin
                    next_state = S_WAIT;
                end
            end
            S_RD_LO: begin
                next_state = S_WAIT;
            end
            S_WAIT: begin
                next_state = S_EXEC;
            end
            S_EXEC: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
            rel <= `REL_EQ;
            is_double <= 1'b0;
            src_a <= 5'h00;
            src_b <= 5'h00;
        end else begin
            state <= next_state;
            if (take) begin
                rel <= minor_rel;
                is_double <= minor_double;
                src_a <= issue_instr[`SRC_A_MSB:`SRC_A_LSB];
                src_b <= issue_instr[`SRC_B_MSB:`SRC_B_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // register file reads
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gpr_rd_en <= 1'b0;
            gpr_addr_a <= 5'h00;
            gpr_addr_b <= 5'h00;
        end else if (take) begin
            gpr_rd_en <= 1'b1;
            gpr_addr_a <= issue_instr[`SRC_A_MSB:`SRC_A_LSB];
            gpr_addr_b <= issue_instr[`SRC_B_MSB:`SRC_B_LSB];
        end else if (state == S_RD_HI && pair_mode) begin
            // second register of each pair follows the first
            gpr_rd_en <= 1'b1;
            gpr_addr_a <= src_a + `PAIR_STEP;
            gpr_addr_b <= src_b + `PAIR_STEP;
        end else begin
            gpr_rd_en <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // operand capture
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            op_a <= 64'h0;
            op_b <= 64'h0;
        end else if (state == S_RD_LO) begin
            op_a[63:32] <= data_a_ext[31:0];
            op_b[63:32] <= data_b_ext[31:0];
        end else if (state == S_WAIT) begin
            if (pair_mode) begin
                op_a[31:0] <= data_a_ext[31:0];
                op_b[31:0] <= data_b_ext[31:0];
            end else begin
                op_a <= data_a_ext;
                op_b <= data_b_ext;
            end
        end
    end

    // ----------------------------------------------------------------
    // comparators, one per precision
    // ----------------------------------------------------------------
    wire dbl_nan;
    wire dbl_inf;
    wire dbl_eq;
    wire dbl_gt;
    wire sgl_nan;
    wire sgl_inf;
    wire sgl_eq;
    wire sgl_gt;

    fp_order_cmp #(
        .EXP_W(11),
        .FRAC_W(52)
    ) u_cmp_double (
        .a(op_a),
        .b(op_b),
        .nan_any(dbl_nan),
        .inf_any(dbl_inf),
        .equal(dbl_eq),
        .greater(dbl_gt)
    );

    fp_order_cmp #(
        .EXP_W(8),
        .FRAC_W(23)
    ) u_cmp_single (
        .a(op_a[31:0]),
        .b(op_b[31:0]),
        .nan_any(sgl_nan),
        .inf_any(sgl_inf),
        .equal(sgl_eq),
        .greater(sgl_gt)
    );

    wire any_nan = is_double ? dbl_nan : sgl_nan;
    wire any_inf = is_double ? dbl_inf : sgl_inf;
    wire ord_eq = is_double ? dbl_eq : sgl_eq;
    wire ord_gt = is_double ? dbl_gt : sgl_gt;

    reg next_flag;

    always @* begin
        case (rel)
            `REL_EQ: next_flag = any_nan | ord_eq;
            `REL_GE: next_flag = any_nan | ord_gt | ord_eq;
            `REL_GT: next_flag = any_nan | ord_gt;
            // ordered and not greater is less or equal
            default: next_flag = any_nan | ~ord_gt;
        endcase
    end

    // ----------------------------------------------------------------
    // results; no invalid-operation output exists, so that bit stays put
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_we <= 1'b0;
            flag_value <= `FLAG_RESET;
            infinity_seen_set <= 1'b0;
        end else if (state == S_EXEC) begin
            flag_we <= 1'b1;
            flag_value <= next_flag;
            infinity_seen_set <= any_inf;
        end else begin
            flag_we <= 1'b0;
            infinity_seen_set <= 1'b0;
        end
    end
endmodule // unordered_fp_compare

`default_nettype wire

/* File: tb/gpr_file_model.sv */
// register file model answering the compare unit's reads
// assumes read data is wanted in the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none

module gpr_file_model #(
    parameter XLEN = 32
) (
    input wire logic core_clk, // core clock
    input wire logic gpr_rd_en, // read strobe
    input wire logic [4:0] gpr_addr_a, // first index
    input wire logic [4:0] gpr_addr_b, // second index
    output logic [XLEN-1:0] gpr_data_a, // first data
    output logic [XLEN-1:0] gpr_data_b // second data
);
    logic [XLEN-1:0] mem [0:31];
    initial begin
        gpr_data_a = '0;
        gpr_data_b = '0;
    end
    // idle cycles flip the data so a late sample cannot match by luck
    always @(posedge core_clk) begin
        if (gpr_rd_en) begin
            gpr_data_a <= mem[gpr_addr_a];
            gpr_data_b <= mem[gpr_addr_b];
        end else begin
            gpr_data_a <= ~gpr_data_a;
            gpr_data_b <= ~gpr_data_b;
        end
    end
endmodule // gpr_file_model
`default_nettype wire

/* File: tb/unordered_fp_compare_checker.sv */
// port assertions for the unordered compare unit
// assumes it is bound into every instance of the compare unit
`timescale 1ns/1ns
`default_nettype none
`include "unord_cmp_regs.vh"

module unord_cmp_checker #(
    parameter XLEN = 32
) (
    input wire logic core_clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic issue_valid, // word offered
    input wire logic [31:0] issue_instr, // word
    input wire logic issue_ready, // unit idle
    input wire logic issue_claimed, // word in group
    input wire logic gpr_rd_en, // read strobe
    input wire logic [4:0] gpr_addr_a, // first index
    input wire logic [4:0] gpr_addr_b, // second index
    input wire logic [XLEN-1:0] gpr_data_a, // first data
    input wire logic [XLEN-1:0] gpr_data_b, // second data
    input wire logic flag_we, // flag write
    input wire logic flag_value, // flag value
    input wire logic infinity_seen_set // infinity bit set
);
    localparam int DLAT = (XLEN == 32) ? 5 : 4;
    wire logic [7:0] minor = issue_instr[`MINOR_MSB:`MINOR_LSB];
    wire logic [4:0] src_a = issue_instr[`SRC_A_MSB:`SRC_A_LSB];
    wire logic [4:0] src_b = issue_instr[`SRC_B_MSB:`SRC_B_LSB];
    wire logic dbl = minor[4];
    wire logic in_group = (issue_instr[`MAJOR_MSB:`MAJOR_LSB] == `MAJOR_FP_GROUP) &&
        (minor inside {`CMP_UNORD_EQ_DOUBLE, `CMP_UNORD_GE_DOUBLE, `CMP_UNORD_GT_DOUBLE,
        `CMP_UNORD_LE_DOUBLE, `CMP_UNORD_EQ_SINGLE, `CMP_UNORD_GE_SINGLE,
        `CMP_UNORD_GT_SINGLE, `CMP_UNORD_LE_SINGLE});

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_take;
        issue_valid && issue_claimed && issue_ready;
    endsequence
    sequence s_busy3;
        (!flag_we && !issue_ready) [*3];
    endsequence

    chk_claim_decode: assert property (issue_claimed == in_group)
        else $error("group decode wrong");
    chk_read_addr: assert property (s_take |=> gpr_rd_en && gpr_addr_a == $past(src_a) &&
        gpr_addr_b == $past(src_b))
        else $error("first read indices wrong");
    chk_busy_gap: assert property (s_take |=> s_busy3)
        else $error("early result or ready");
    chk_single_lat: assert property (s_take ##0 !dbl |-> ##4 flag_we && issue_ready)
        else $error("single result late");
    chk_double_lat: assert property (s_take ##0 dbl |-> ##[DLAT:DLAT] flag_we)
        else $error("double result late");
    chk_pair_read: assert property (s_take ##0 (dbl && XLEN == 32) |=> ##1 gpr_rd_en &&
        gpr_addr_a == $past(src_a, 2) + `PAIR_STEP)
        else $error("second half read wrong");
    chk_inf_pulse: assert property (infinity_seen_set |-> flag_we)
        else $error("infinity set without result");
    chk_flag_hold: assert property ($changed(flag_value) |-> flag_we)
        else $error("flag moved without write");
    chk_we_single: assert property (flag_we |=> !flag_we)
        else $error("flag write too long");
endmodule // unord_cmp_checker

bind unordered_fp_compare unord_cmp_checker #(.XLEN(XLEN)) chk_i (.core_clk(core_clk),
    .nrst(nrst), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_ready(issue_ready), .issue_claimed(issue_claimed), .gpr_rd_en(gpr_rd_en),
    .gpr_addr_a(gpr_addr_a), .gpr_addr_b(gpr_addr_b), .gpr_data_a(gpr_data_a),
    .gpr_data_b(gpr_data_b), .flag_we(flag_we), .flag_value(flag_value),
    .infinity_seen_set(infinity_seen_set));
`default_nettype wire

/* File: tb/unordered_fp_compare_tb_top.sv */
// self-checking bench for the unordered compare unit
// assumes the register file model and bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`include "unord_cmp_regs.vh"

module unordered_fp_compare_tb_top;
    localparam int XLEN = 32;
    logic core_clk, nrst, issue_valid;
    logic [31:0] issue_instr;
    wire logic issue_ready, issue_claimed, gpr_rd_en, flag_we, flag_value, inf_set;
    wire logic [4:0] addr_a, addr_b;
    wire logic [XLEN-1:0] data_a, data_b;
    // second unit on a wide machine: one register per double operand
    wire logic rdy64, clm64, rd64, we64, fv64, inf64;
    wire logic [4:0] ia64, ib64;
    wire logic [63:0] da64, db64;
    int errors = 0;
    int num_checks = 0;
    int seed = 75;
    logic [7:0] ops [0:7] = '{`CMP_UNORD_EQ_DOUBLE, `CMP_UNORD_GE_DOUBLE, `CMP_UNORD_GT_DOUBLE,
        `CMP_UNORD_LE_DOUBLE, `CMP_UNORD_EQ_SINGLE, `CMP_UNORD_GE_SINGLE,
        `CMP_UNORD_GT_SINGLE, `CMP_UNORD_LE_SINGLE};
    logic [7:0] bad [0:3] = '{8'h2c, 8'h3e, 8'h3c, 8'h18};

    unordered_fp_compare #(.XLEN(XLEN)) uut (.core_clk(core_clk), .nrst(nrst),
        .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_ready(issue_ready),
        .issue_claimed(issue_claimed), .gpr_rd_en(gpr_rd_en), .gpr_addr_a(addr_a),
        .gpr_addr_b(addr_b), .gpr_data_a(data_a), .gpr_data_b(data_b), .flag_we(flag_we),
        .flag_value(flag_value), .infinity_seen_set(inf_set));
    gpr_file_model #(.XLEN(XLEN)) regs (.core_clk(core_clk), .gpr_rd_en(gpr_rd_en),
        .gpr_addr_a(addr_a), .gpr_addr_b(addr_b), .gpr_data_a(data_a), .gpr_data_b(data_b));
    unordered_fp_compare #(.XLEN(64)) uut64 (.core_clk(core_clk), .nrst(nrst),
        .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_ready(rdy64),
        .issue_claimed(clm64), .gpr_rd_en(rd64), .gpr_addr_a(ia64),
        .gpr_addr_b(ib64), .gpr_data_a(da64), .gpr_data_b(db64), .flag_we(we64),
        .flag_value(fv64), .infinity_seen_set(inf64));
    gpr_file_model #(.XLEN(64)) regs64 (.core_clk(core_clk), .gpr_rd_en(rd64),
        .gpr_addr_a(ia64), .gpr_addr_b(ib64), .gpr_data_a(da64), .gpr_data_b(db64));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // integer ordering key; sign-magnitude folded so that -0 equals +0
    function automatic longint fp_key(input bit dbl, input logic [63:0] x, output bit nan,
        output bit infinity_seen_bit);
        longint m;
        m = dbl ? longint'(x[62:0]) : longint'(x[30:0]);
        nan = dbl ? (&x[62:52] && |x[51:0]) : (&x[30:23] && |x[22:0]);
        infinity_seen_bit = dbl ? (&x[62:52] && !(|x[51:0])) : (&x[30:23] && !(|x[22:0]));
        return (dbl ? x[63] : x[31]) ? -m : m;
    endfunction

    function automatic logic [63:0] pick(input bit dbl, input logic [63:0] other);
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        case ($unsigned($random(seed)) % 6)
            0: r = dbl ? {r[63], 11'h7ff, 52'h0} : {32'h0, r[31], 8'hff, 23'h0};
            1: r = dbl ? {r[63], 11'h7ff, r[51:1], 1'b1} : {32'h0, r[31], 8'hff, r[22:1], 1'b1};
            2: r = dbl ? {r[63], 63'h0} : {32'h0, r[31], 31'h0};
            3: r = other;
            default: ;
        endcase
        return dbl ? r : {32'h0, r[31:0]};
    endfunction

    task automatic run(input int k, input logic [4:0] ra);
        logic [63:0] a, b;
        logic [4:0] rb;
        bit dbl, na, nb, ia, ib, rel;
        longint ka, kb;
        int n, n64;
        bit f64, i64;
        dbl = (k < 4);
        rb = ra ^ 5'h10;
        a = pick(dbl, 64'h0);
        b = pick(dbl, a);
        ka = fp_key(dbl, a, na, ia);
        kb = fp_key(dbl, b, nb, ib);
        case (k % 4)
            0: rel = (ka == kb);
            1: rel = (ka >= kb);
            2: rel = (ka > kb);
            default: rel = (ka <= kb);
        endcase
        regs.mem[ra] = dbl ? a[63:32] : a[31:0];
        regs.mem[rb] = dbl ? b[63:32] : b[31:0];
        regs.mem[ra + 5'h01] = a[31:0];
        regs.mem[rb + 5'h01] = b[31:0];
        // upper half filled with junk so a single form must ignore it
        regs64.mem[ra] = dbl ? a : {~a[31:0], a[31:0]};
        regs64.mem[rb] = dbl ? b : {~b[31:0], b[31:0]};
        @(negedge core_clk);
        issue_valid = 1'b1;
        issue_instr = {`MAJOR_FP_GROUP, 5'($random(seed)), ra, rb, 3'($random(seed)), ops[k]};
        #1;
        check("claimed", 8'h1, {7'h0, issue_claimed & issue_ready});
        check("claimed 64", 8'h1, {7'h0, clm64 & rdy64});
        @(negedge core_clk);
        issue_valid = 1'b0;
        n = 0;
        n64 = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (we64 === 1'b1 && n64 == 0) begin
                n64 = n;
                f64 = fv64;
                i64 = inf64;
            end
        end while (flag_we !== 1'b1 && n < 12);
        check("latency", dbl ? 8'h4 : 8'h3, 8'(n));
        check("flag", {7'h0, na | nb | rel}, {7'h0, flag_value});
        check("infinity", {7'h0, ia | ib}, {7'h0, inf_set});
        check("latency 64", 8'h3, 8'(n64));
        check("flag 64", {7'h0, na | nb | rel}, {7'h0, f64});
        check("infinity 64", {7'h0, ia | ib}, {7'h0, i64});
        if (flag_we !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask

    initial begin
        nrst = 1'b0;
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        #1;
        check("reset flag", {7'h0, `FLAG_RESET}, {7'h0, flag_value});
        check("reset ready", 8'h1, {7'h0, issue_ready});
        for (int i = 0; i < 5; i++) begin
            @(negedge core_clk);
            issue_valid = 1'b1;
            issue_instr = {(i == 4) ? 6'h31 : `MAJOR_FP_GROUP, 18'h0, (i == 4) ? ops[0] : bad[i]};
            #1;
            check("unclaimed", 8'h0, {7'h0, issue_claimed | clm64});
            @(posedge core_clk);
            #1;
            check("no read", 8'h0, {7'h0, gpr_rd_en});
            check("still ready", 8'h1, {7'h0, issue_ready});
        end
        @(negedge core_clk);
        issue_valid = 1'b0;
        run(2, 5'h1f);
        run(3, 5'h0f);
        for (int i = 0; i < 240; i++) run(i % 8, 5'($random(seed)));
        stop_test();
    end
endmodule // unordered_fp_compare_tb_top
`default_nettype wire
